// [include/alu16_pkg.sv]
// package of constants and codes for the sixteen-bit alu slice
// Notes on behaviour
// RL1: 16-bit cascadable alu slice with a 64 by 16 register file.
// RL2: instruction supplies a and b addresses reading two file ports.
// RL3: result may drive the output bus, write back, or both.
// RL4: zero, sign and overflow flags come from the current alu result.
// RL5: controller drives source select on instruction bits 0 to 2.
// RL6: bits 3 to 5 pick one of eight alu functions.
// RL7: bits 6 to 8 plus extend bit 9 give sixteen destinations.
// RL8: extend bit high selects the eight classic destinations.
// RL9: extend bit low selects the eight added destinations.
// RL10: data inputs load file and aux register bypassing the alu.
// RL11: added codes shift aux alone and load file or aux directly.
// RL12: accumulate code: aux gets alu result, file at b gets data.
// RL13: bypass code: file gets data, aux gets result, output shows a.
// RL14: source codes pick r,s pairs from a, b, aux, data and zero.
// RL15: classic codes 8 to f store result, halves or doubles as tabled.
// RL16: added codes 0 to 7 as tabled; output otherwise the result.
// RL17: wider words chain carry out into the next slice carry in.
// RL18: writes and aux updates on rising clock; reads and flags combinational.
package alu16_pkg;
   localparam int WIDTH      = 16;
   localparam int DEPTH      = 64;
   localparam int ADDR_W     = 6;
   localparam int INSTR_W    = 10;
   localparam int SRC_LSB    = 0;
   localparam int FN_LSB     = 3;
   localparam int DEST_LSB   = 6;
   localparam int EXT_BIT    = 9;
   localparam logic [15:0] AUX_RESET = 16'h0000;

   typedef enum logic [2:0] {
      src_a_aux    = 3'h0,
      src_a_b      = 3'h1,
      src_zero_aux = 3'h2,
      src_zero_b   = 3'h3,
      src_zero_a   = 3'h4,
      src_data_a   = 3'h5,
      src_data_aux = 3'h6,
      src_data_zero= 3'h7
   } alu16_src_e;

   typedef enum logic [2:0] {
      fn_add              = 3'h0,
      fn_s_minus_r        = 3'h1,
      fn_r_minus_s        = 3'h2,
      fn_or               = 3'h3,
      fn_and              = 3'h4,
      fn_inverted_r_and_s = 3'h5,
      fn_xor              = 3'h6,
      fn_xnor             = 3'h7
   } alu16_fn_e;

   typedef enum logic [3:0] {
      dest_direct_load_accumulate     = 4'h0,
      dest_direct_load_bypass         = 4'h1,
      dest_result_file_data_aux       = 4'h2,
      dest_result_file_data_aux_out_a = 4'h3,
      dest_aux_halve                  = 4'h4,
      dest_data_to_file               = 4'h5,
      dest_aux_double                 = 4'h6,
      dest_data_to_aux                = 4'h7,
      dest_aux_only                   = 4'h8,
      dest_none                       = 4'h9,
      dest_file_out_a                 = 4'hA,
      dest_file_out_result            = 4'hB,
      dest_both_shift_down            = 4'hC,
      dest_file_shift_down            = 4'hD,
      dest_both_shift_up              = 4'hE,
      dest_file_shift_up              = 4'hF
   } alu16_dest_e;
endpackage

// [logic/alu16_slice.sv]
// sixteen-bit alu slice with register file and auxiliary register
`timescale 1ns/100ps
`default_nettype none
module alu16_slice #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 64
) (
   // clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         rst,
   // microinstruction and addresses
   input  wire logic [alu16_pkg::INSTR_W-1:0] instr,
   input  wire logic [alu16_pkg::ADDR_W-1:0]  addr_a,
   input  wire logic [alu16_pkg::ADDR_W-1:0]  addr_b,
   // data and carry
   input  wire logic [WIDTH-1:0]             data_in,
   input  wire logic                         carry_in,
   // shift boundary inputs
   input  wire logic                         file_shift_in_up,
   input  wire logic                         file_shift_in_down,
   input  wire logic                         aux_shift_in_up,
   input  wire logic                         aux_shift_in_down,
   // result and status
   output logic      [WIDTH-1:0]             result_out,
   output logic                              carry_out,
   output logic                              flag_zero,
   output logic                              flag_sign,
   output logic                              flag_overflow,
   // shift boundary outputs
   output logic                              file_shift_out_up,
   output logic                              file_shift_out_down,
   output logic                              aux_shift_out_up,
   output logic                              aux_shift_out_down,
   // auxiliary register contents
   output logic      [WIDTH-1:0]             aux_out
);
   import alu16_pkg::*;

   logic [WIDTH-1:0] file_q [DEPTH];  // RL1
   logic [WIDTH-1:0] aux_q;
   logic [WIDTH-1:0] word_a, word_b, op_r, op_s, fres;
   logic             c_out, ovf;
   logic [3:0]       dest;
   logic [2:0]       src, fn;

   // full add of x + y + c giving sum, carry and signed overflow
   function automatic logic [WIDTH+1:0] add3(input logic [WIDTH-1:0] x,
                                            input logic [WIDTH-1:0] y,
                                            input logic c);
      logic [WIDTH:0] s;
      logic           v;
      s = {1'b0, x} + {1'b0, y} + {{WIDTH{1'b0}}, c};
      v = (x[WIDTH-1] == y[WIDTH-1]) && (s[WIDTH-1] != x[WIDTH-1]);
      return {v, s};
   endfunction

   assign src  = instr[SRC_LSB +: 3];                       // RL5
   assign fn   = instr[FN_LSB +: 3];                        // RL6
   assign dest = {instr[EXT_BIT], instr[DEST_LSB +: 3]};    // RL7 RL8 RL9

   assign word_a = file_q[addr_a];  // RL2
   assign word_b = file_q[addr_b];  // RL2

   always_comb begin  // RL14
      case (src)
         src_a_aux:    begin op_r = word_a;        op_s = aux_q;         end
         src_a_b:      begin op_r = word_a;        op_s = word_b;        end
         src_zero_aux: begin op_r = '0;            op_s = aux_q;         end
         src_zero_b:   begin op_r = '0;            op_s = word_b;        end
         src_zero_a:   begin op_r = '0;            op_s = word_a;        end
         src_data_a:   begin op_r = data_in;       op_s = word_a;        end
         src_data_aux: begin op_r = data_in;       op_s = aux_q;         end
         default:      begin op_r = data_in;       op_s = '0;            end
      endcase
   end

   always_comb begin  // RL6
      logic [WIDTH+1:0] t;
      t     = '0;
      fres  = '0;
      c_out = 1'b0;
      ovf   = 1'b0;
      case (fn)
         fn_add:       t = add3(op_r, op_s, carry_in);
         fn_s_minus_r: t = add3(~op_r, op_s, carry_in);
         fn_r_minus_s: t = add3(op_r, ~op_s, carry_in);
         fn_or:               fres = op_r | op_s;
         fn_and:              fres = op_r & op_s;
         fn_inverted_r_and_s: fres = ~op_r & op_s;
         fn_xor:              fres = op_r ^ op_s;
         default:             fres = ~(op_r ^ op_s);
      endcase
      if (fn == fn_add || fn == fn_s_minus_r || fn == fn_r_minus_s) begin
         fres  = t[WIDTH-1:0];
         c_out = t[WIDTH];        // RL17
         ovf   = t[WIDTH+1];
      end
   end

   assign carry_out     = c_out;
   assign flag_zero     = (fres == '0);     // RL4
   assign flag_sign     = fres[WIDTH-1];    // RL4
   assign flag_overflow = ovf;              // RL4

   // output bus: the a word for the out-a codes, else the result
   always_comb begin  // RL3 RL13
      case (dest)
         dest_file_out_a,
         dest_direct_load_bypass,
         dest_result_file_data_aux_out_a: result_out = word_a;
         default:                         result_out = fres;
      endcase
   end

   // boundary bits leaving during shifts
   assign file_shift_out_down = fres[0];
   assign file_shift_out_up   = fres[WIDTH-1];
   assign aux_shift_out_down  = aux_q[0];
   assign aux_shift_out_up    = aux_q[WIDTH-1];

   // register file write at b address
   always_ff @(posedge core_clk) begin  // RL18
      case (dest)
         dest_direct_load_accumulate,                       // RL12
         dest_direct_load_bypass,                           // RL13
         dest_data_to_file:                                 // RL10 RL11
            file_q[addr_b] <= data_in;
         dest_result_file_data_aux,
         dest_result_file_data_aux_out_a,
         dest_file_out_a,
         dest_file_out_result:                              // RL3 RL15
            file_q[addr_b] <= fres;
         dest_both_shift_down,
         dest_file_shift_down:                              // RL15
            file_q[addr_b] <= {file_shift_in_down, fres[WIDTH-1:1]};
         dest_both_shift_up,
         dest_file_shift_up:                                // RL15
            file_q[addr_b] <= {fres[WIDTH-2:0], file_shift_in_up};
         default: ;
      endcase
   end

   // auxiliary register updates
   always_ff @(posedge core_clk or posedge rst) begin  // RL18
      if (rst) begin
         aux_q <= AUX_RESET;
      end else begin
         case (dest)
            dest_aux_only,
            dest_direct_load_accumulate,                    // RL12
            dest_direct_load_bypass:                        // RL13
               aux_q <= fres;
            dest_result_file_data_aux,
            dest_result_file_data_aux_out_a,
            dest_data_to_aux:                               // RL10 RL11 RL16
               aux_q <= data_in;
            dest_both_shift_down,
            dest_aux_halve:                                 // RL11 RL15 RL16
               aux_q <= {aux_shift_in_down, aux_q[WIDTH-1:1]};
            dest_both_shift_up,
            dest_aux_double:                                // RL11 RL15 RL16
               aux_q <= {aux_q[WIDTH-2:0], aux_shift_in_up};
            default: ;
         endcase
      end
   end

   assign aux_out = aux_q;
endmodule
`default_nettype wire

// [dv/alu16_slice_monitor.sv]
// port assertions for the alu slice
`timescale 1ns/100ps
`default_nettype none
module alu16_slice_monitor #(parameter int WIDTH = 16, parameter int DEPTH = 64) (
   // clock, reset and status
   input wire logic core_clk, rst, carry_out, flag_zero, flag_sign, flag_overflow,
   // shift boundary bits
   input wire logic aux_shift_in_up, aux_shift_in_down, file_shift_out_down,
   input wire logic aux_shift_out_up, aux_shift_out_down,
   // instruction and data words
   input wire logic [alu16_pkg::INSTR_W-1:0] instr,
   input wire logic [WIDTH-1:0] data_in, result_out, aux_out
);
   import alu16_pkg::*;
   wire logic [3:0] dc = {instr[EXT_BIT], instr[DEST_LSB+:3]};
   wire logic out_a = dc inside {4'h1, 4'h3, 4'hA};
   default clocking mon_cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence aux_down_s; dc == 4'h4 || dc == 4'hC; endsequence
   sequence aux_up_s; dc == 4'h6 || dc == 4'hE; endsequence
   zero_flag_a: assert property (!out_a |-> flag_zero == (result_out == 16'h0000))
      else $error("zero flag mismatch");
   sign_flag_a: assert property (!out_a |-> flag_sign == result_out[15] && file_shift_out_down == result_out[0])
      else $error("sign or shift tap mismatch");
   logic_flags_a: assert property (instr[FN_LSB+:3] >= 3'h3 |-> !flag_overflow && !carry_out)
      else $error("logic function set carry or overflow");
   aux_taps_a: assert property (aux_shift_out_up == aux_out[15] && aux_shift_out_down == aux_out[0])
      else $error("aux shift taps wrong");
   aux_result_a: assert property (dc inside {4'h0, 4'h8} |=> aux_out == $past(result_out))
      else $error("aux not loaded with result");
   aux_data_a: assert property (dc inside {4'h2, 4'h3, 4'h7} |=> aux_out == $past(data_in))
      else $error("aux not loaded with data");
   aux_hold_a: assert property (dc inside {4'h5, 4'h9, 4'hA, 4'hB, 4'hD, 4'hF} |=> $stable(aux_out))
      else $error("aux changed unexpectedly");
   aux_halve_a: assert property (aux_down_s |=> aux_out == ({$past(aux_shift_in_down), 15'h0000} | ($past(aux_out) >> 1)))
      else $error("aux halve wrong");
   aux_double_a: assert property (aux_up_s |=> aux_out == (($past(aux_out) << 1) | {15'h0000, $past(aux_shift_in_up)}))
      else $error("aux double wrong");
endmodule
bind alu16_slice alu16_slice_monitor #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mon (.*);
`default_nettype wire

// [dv/alu16_pipe_model.sv]
// microinstruction pipeline register feeding the slice
`timescale 1ns/100ps
`default_nettype none
module alu16_pipe_model (
   // clock
   input  wire logic        core_clk,
   // word from the sequencer and its registered copy
   input  wire logic [38:0] next_word,
   output logic      [38:0] word_q
);
   // fields: instr, addr_a, addr_b, data, carry
   always_ff @(posedge core_clk) word_q <= next_word;
endmodule
`default_nettype wire

// [dv/alu16_slice_tb.sv]
// self-checking bench for the alu slice
`timescale 1ns/100ps
`default_nettype none
module alu16_slice_tb;
   import alu16_pkg::*;
   typedef struct {logic [2:0] s; logic [2:0] f; logic c; logic [15:0] d, y; logic v;} alu16_row_s;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [38:0] nw = {10'h240, 29'h0000_0000};
   logic [38:0] wq;
   logic [3:0] shin = 4'h9;
   logic [15:0] result_out, aux_out;
   logic carry_out, flag_zero, flag_sign, flag_overflow;
   int fails = 0;
   int checked = 0;
   alu16_row_s rows [9] = '{'{3'h0, 3'h0, 1'b0, 16'h0000, 16'h00F5, 1'b0},
      '{3'h1, 3'h1, 1'b1, 16'h0000, 16'hFFFE, 1'b0}, '{3'h2, 3'h2, 1'b1, 16'h0000, 16'hFF10, 1'b0},
      '{3'h3, 3'h3, 1'b0, 16'h0000, 16'h0003, 1'b0}, '{3'h4, 3'h4, 1'b0, 16'h0000, 16'h0000, 1'b0},
      '{3'h5, 3'h5, 1'b0, 16'h1234, 16'h0001, 1'b0}, '{3'h6, 3'h6, 1'b0, 16'h1234, 16'h12C4, 1'b0},
      '{3'h7, 3'h7, 1'b0, 16'h1234, 16'hEDCB, 1'b0}, '{3'h7, 3'h0, 1'b1, 16'h7FFF, 16'h8000, 1'b1}};
   alu16_pipe_model pipe (.core_clk(core_clk), .next_word(nw), .word_q(wq));
   alu16_slice dut (.core_clk(core_clk), .rst(rst), .instr(wq[38:29]), .addr_a(wq[28:23]),
      .addr_b(wq[22:17]), .data_in(wq[16:1]), .carry_in(wq[0]), .file_shift_in_up(shin[0]),
      .file_shift_in_down(shin[1]), .aux_shift_in_up(shin[2]), .aux_shift_in_down(shin[3]),
      .result_out(result_out), .carry_out(carry_out), .flag_zero(flag_zero),
      .flag_sign(flag_sign), .flag_overflow(flag_overflow), .file_shift_out_up(),
      .file_shift_out_down(), .aux_shift_out_up(), .aux_shift_out_down(), .aux_out(aux_out));
   function automatic logic [38:0] mk(logic [3:0] dst, logic [2:0] fn, logic [2:0] src,
      logic [5:0] a, logic [5:0] b, logic [15:0] d, logic c);
      return {dst, fn, src, a, b, d, c};
   endfunction
   // word goes in at a falling edge, is registered at the next rising one
   task automatic issue(logic [38:0] w);
      @(negedge core_clk);
      nw = w;
      @(posedge core_clk);
      #1;
   endtask
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial forever #4 core_clk = ~core_clk;
   initial begin
      #2000;
      fails++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      chk(aux_out, 16'h0000);
      issue(mk(4'h5, 3'h0, 3'h0, 6'h00, 6'h01, 16'h0005, 1'b0));
      issue(mk(4'h5, 3'h0, 3'h0, 6'h00, 6'h02, 16'h0003, 1'b0));
      issue(mk(4'h7, 3'h0, 3'h0, 6'h00, 6'h00, 16'h00F0, 1'b0));
      foreach (rows[i]) begin
         issue(mk(4'h9, rows[i].f, rows[i].s, 6'h01, 6'h02, rows[i].d, rows[i].c));
         chk(result_out, rows[i].y);
         chk({15'h0000, flag_overflow}, {15'h0000, rows[i].v});
         chk({14'h0000, flag_zero, flag_sign}, {14'h0000, rows[i].y == 16'h0000, rows[i].y[15]});
      end
      $display("table test done");
      issue(mk(4'h0, 3'h0, 3'h0, 6'h01, 6'h03, 16'hABCD, 1'b0));
      chk(result_out, 16'h00F5);
      issue(mk(4'h1, 3'h0, 3'h1, 6'h01, 6'h02, 16'h0042, 1'b0));
      chk(result_out, 16'h0005);
      chk(aux_out, 16'h00F5);
      issue(mk(4'h4, 3'h3, 3'h4, 6'h02, 6'h00, 16'h0000, 1'b0));
      chk(result_out, 16'h0042);
      chk(aux_out, 16'h0008);
      issue(mk(4'h6, 3'h3, 3'h4, 6'h03, 6'h00, 16'h0000, 1'b0));
      chk(result_out, 16'hABCD);
      chk(aux_out, 16'h8004);
      issue(mk(4'hE, 3'h3, 3'h4, 6'h01, 6'h05, 16'h0000, 1'b0));
      chk(aux_out, 16'h0008);
      issue(mk(4'hA, 3'h3, 3'h7, 6'h05, 6'h06, 16'h1111, 1'b0));
      chk(result_out, 16'h000B);
      chk(aux_out, 16'h0010);
      issue(mk(4'h9, 3'h3, 3'h4, 6'h06, 6'h00, 16'h0000, 1'b0));
      chk(result_out, 16'h1111);
      chk(aux_out, 16'h0010);
      // all-ones plus carry wraps to zero and carries into the next slice
      issue(mk(4'h9, 3'h0, 3'h7, 6'h00, 6'h00, 16'hFFFF, 1'b1));
      chk(result_out, 16'h0000);
      chk({13'h0000, carry_out, flag_zero, flag_overflow}, 16'h0006);
      $display("hand tests done");
      summarize();
   end
endmodule
`default_nettype wire
